// ---- verilog/amf_consts.vh ----
// Constants for the customer-end multiframe, service channel and scrambler block
`ifndef AMF_CONSTS_VH
`define AMF_CONSTS_VH
`define AMF_TX_OFFSET    10'h0247
`define AMF_GUARD_HI     5'h10
`define AMF_GUARD_LO     5'h02
`define AMF_TAP_A        9
`define AMF_TAP_B        11
`define AMF_SVC_PER_FRAME 2'h3
`define AMF_ST_ALIGNED   2'h0
`define AMF_ST_PREALARM  2'h1
`define AMF_ST_OUT       2'h2
`endif

// ---- verilog/amf_line_framer.v ----
// Customer-end multiframe alignment, frame timing, service channel and scrambler
`timescale 1ns/1ps
`include "amf_consts.vh"
module amf_line_framer #(
  parameter TX_OFFSET = `AMF_TX_OFFSET
) (
  input  wire       clk,           // System clock
  input  wire       sys_rst,       // Synchronous reset, high
  input  wire       bitTick,       // One pulse per line bit period
  input  wire       rxFrameStart,  // First bit of a received frame
  input  wire       rxSvcBit,      // Received service channel bit
  input  wire       rxSvcValid,    // Qualifies rxSvcBit
  input  wire       rxLineBit,     // Scrambled received bit
  input  wire       rxLineValid,   // Qualifies rxLineBit
  input  wire       txData,        // Clear transmit bit
  input  wire       txDataValid,   // Qualifies txData
  input  wire       txSvcReq,      // Framer asks for next service bit
  input  wire [8:0] txMsg,         // Outgoing message information bits
  input  wire       txMsgLoad,     // Load txMsg
  input  wire       txNeedAck,     // Loaded message awaits acknowledge
  input  wire       rxAckSeen,     // Exchange end acknowledged
  input  wire       linkActive,    // Link fully active
  input  wire       exchangeGo,    // Exchange end allows transmission
  input  wire       powerDown,     // Power down request
  input  wire       wholeActivate, // Activate customer interface too
  output reg        txFrameStart,  // First bit of upstream frame
  output reg        txSvcBit,      // Outgoing service channel bit
  output reg  [8:0] rxMsg,         // Received message information bits
  output reg        rxMsgValid,    // One pulse per good multiframe
  output reg  [1:0] mfState,       // Multiframe alignment state
  output reg        mfLoss,        // Loss of multiframe pulse
  output wire       txBusy,        // Waiting for acknowledge
  output wire       txDataReady,   // Low while a ZERO is forced
  output reg        txLineBit,     // Scrambled transmit bit
  output reg        txLineValid,   // Qualifies txLineBit
  output reg        txParityBit,   // Frame parity bit to send
  output reg        rxData,        // Descrambled received bit
  output reg        rxDataValid,   // Qualifies rxData
  output wire       txDrive,       // Transmitter may drive the line
  output wire       custIfEnable   // Customer interface activated
);

  // Build the sixteen service bits from nine information bits
  function [15:0] svcBuild;
    input [8:0] inf;
    begin
      svcBuild[15:13] = inf[8:6];
      svcBuild[12]    = ~^inf[8:6];
      svcBuild[11:9]  = inf[5:3];
      svcBuild[8]     = ^inf[5:3];
      svcBuild[7:5]   = inf[2:0];
      svcBuild[4]     = ^inf[2:0];
      svcBuild[3:0]   = svcBuild[15:12] ^ svcBuild[11:8] ^ svcBuild[7:4];
    end
  endfunction

  // Transmit gating
  wire txOn;                        // Transmitter allowed on line
  assign txOn = linkActive & exchangeGo & ~powerDown;
  assign txDrive = txOn;
  assign custIfEnable = linkActive & wholeActivate;

  // Upstream frame offset counter
  reg [9:0] offCnt_reg;             // Bit periods since rx frame start
  reg       offRun_reg;             // Counting in progress

  // Offset timing from received frame
  always @(posedge clk) begin
    if (sys_rst) begin
      offCnt_reg   <= 10'h0000;
      offRun_reg   <= 1'b0;
      txFrameStart <= 1'b0;
    end else begin
      txFrameStart <= 1'b0;
      if (rxFrameStart) begin
        // Restart on every received frame
        offCnt_reg <= 10'h0000;
        offRun_reg <= 1'b1;
      end else if (offRun_reg && bitTick) begin
        if (offCnt_reg == TX_OFFSET - 10'h0001) begin
          txFrameStart <= 1'b1;
          offRun_reg   <= 1'b0;
        end
        offCnt_reg <= offCnt_reg + 10'h0001;
      end
    end
  end

  // Receive service channel collection
  reg [1:0]  rxBitIdx_reg;          // Bit within frame
  reg [3:0]  rxNib_reg;             // Current frame bits
  reg [15:0] rxWord_reg;            // Last four frames
  reg [1:0]  rxFrm_reg;             // Frame within multiframe
  wire [3:0] nibNext;               // Nibble including new bit
  wire [15:0] wordNext;             // Window including this frame
  wire       frameDone;             // Fourth bit of frame seen
  wire       chkOk;                 // Parity pattern good
  assign nibNext   = {rxNib_reg[2:0], rxSvcBit};
  assign wordNext  = {rxWord_reg[11:0], nibNext};
  assign frameDone = rxSvcValid && (rxBitIdx_reg == `AMF_SVC_PER_FRAME);
  assign chkOk     = (svcBuild({wordNext[15:13], wordNext[11:9], wordNext[7:5]}) == wordNext);

  // Alignment state machine and message capture
  always @(posedge clk) begin
    if (sys_rst) begin
      rxBitIdx_reg <= 2'h0;
      rxNib_reg    <= 4'h0;
      rxWord_reg   <= 16'h0000;
      rxFrm_reg    <= 2'h0;
      mfState      <= `AMF_ST_OUT;
      mfLoss       <= 1'b0;
      rxMsg        <= 9'h000;
      rxMsgValid   <= 1'b0;
    end else begin
      mfLoss     <= 1'b0;
      rxMsgValid <= 1'b0;
      if (rxFrameStart) begin
        rxBitIdx_reg <= 2'h0;
      end else if (rxSvcValid) begin
        rxBitIdx_reg <= rxBitIdx_reg + 2'h1;
        rxNib_reg    <= nibNext;
      end
      if (frameDone) begin
        rxWord_reg <= wordNext;
        rxFrm_reg  <= rxFrm_reg + 2'h1;
        // Aligned states check only at multiframe end
        if (mfState == `AMF_ST_OUT || rxFrm_reg == 2'h3) begin
          if (chkOk) begin
            mfState   <= `AMF_ST_ALIGNED;
            rxFrm_reg <= 2'h0;
            rxMsg     <= {wordNext[15:13], wordNext[11:9], wordNext[7:5]};
            rxMsgValid <= 1'b1;
          end else begin
            case (mfState)
              `AMF_ST_ALIGNED: begin
                mfState <= `AMF_ST_PREALARM;
              end
              `AMF_ST_PREALARM: begin
                mfState <= `AMF_ST_OUT;
                mfLoss  <= 1'b1;
              end
              default: begin
                mfState <= `AMF_ST_OUT;
              end
            endcase
          end
        end
      end
    end
  end

  // Transmit service channel
  reg [15:0] txWord_reg;            // Message word being repeated
  reg [3:0]  txPos_reg;             // Bit position in multiframe
  reg        busy_reg;              // Awaiting acknowledge
  wire       loadOk;                // Load accepted
  assign txBusy = busy_reg;
  // Accept a load only when idle; a message needing acknowledge also needs the link fully active
  assign loadOk = txMsgLoad && !busy_reg && (!txNeedAck || linkActive);

  // Repeat message every multiframe
  always @(posedge clk) begin
    if (sys_rst) begin
      txWord_reg <= svcBuild(9'h000);
      txPos_reg  <= 4'h0;
      busy_reg   <= 1'b0;
      txSvcBit   <= 1'b0;
    end else begin
      if (loadOk) begin
        txWord_reg <= svcBuild(txMsg);
        busy_reg   <= txNeedAck;
      end else if (rxAckSeen) begin
        busy_reg   <= 1'b0;
      end
      if (txFrameStart) begin
        // Resync nibble position to frame boundary
        txPos_reg <= {txPos_reg[3:2], 2'h0};
      end else if (txSvcReq) begin
        txSvcBit  <= txWord_reg[4'hf - txPos_reg];
        txPos_reg <= txPos_reg + 4'h1;
      end
    end
  end

  // Scrambler and guard
  reg [10:0] txHist_reg;            // Scrambled output history
  reg [4:0]  txOnes_reg;            // Consecutive ONEs sent
  reg        txLow_reg;             // Low threshold active
  reg        txZeroOdd_reg;         // Odd count of ZEROs this frame
  wire [4:0] txThr;                 // Current threshold
  wire       forceNow;              // Next bit must be forced ZERO
  wire       scrBit;                // Scrambled data bit
  assign txThr       = txLow_reg ? `AMF_GUARD_LO : `AMF_GUARD_HI;
  assign forceNow    = (txOnes_reg == txThr);
  assign txDataReady = txOn & ~forceNow;
  assign scrBit      = txData ^ txHist_reg[`AMF_TAP_A-1] ^ txHist_reg[`AMF_TAP_B-1];

  // Transmit line bits
  always @(posedge clk) begin
    if (sys_rst) begin
      txHist_reg    <= 11'h000;
      txOnes_reg    <= 5'h00;
      txLow_reg     <= 1'b0;
      txZeroOdd_reg <= 1'b0;
      txLineBit     <= 1'b1;
      txLineValid   <= 1'b0;
      txParityBit   <= 1'b1;
    end else begin
      txLineValid <= 1'b0;
      txParityBit <= ~txZeroOdd_reg;
      if (txFrameStart) begin
        txZeroOdd_reg <= 1'b0;
      end
      if (txOn && txDataValid) begin
        txLineValid <= 1'b1;
        if (forceNow) begin
          // Inserted ZERO, data bit held back
          txLineBit  <= 1'b0;
          txOnes_reg <= 5'h00;
          txLow_reg  <= 1'b1;
          // A ZERO on the restart cycle counts for the new frame
          txZeroOdd_reg <= txFrameStart | ~txZeroOdd_reg;
        end else begin
          txLineBit  <= scrBit;
          txHist_reg <= {txHist_reg[9:0], scrBit};
          if (scrBit) begin
            txOnes_reg <= txOnes_reg + 5'h01;
          end else begin
            txOnes_reg <= 5'h00;
            txLow_reg  <= 1'b0;
            txZeroOdd_reg <= txFrameStart | ~txZeroOdd_reg;
          end
        end
      end
    end
  end

  // Descrambler with mirrored guard
  reg [10:0] rxHist_reg;            // Received scrambled history
  reg [4:0]  rxOnes_reg;            // Consecutive ONEs received
  reg        rxLow_reg;             // Mirror low threshold
  wire [4:0] rxThr;                 // Mirror threshold
  assign rxThr = rxLow_reg ? `AMF_GUARD_LO : `AMF_GUARD_HI;

  // Remove inserted ZEROs and descramble
  always @(posedge clk) begin
    if (sys_rst) begin
      rxHist_reg  <= 11'h000;
      rxOnes_reg  <= 5'h00;
      rxLow_reg   <= 1'b0;
      rxData      <= 1'b1;
      rxDataValid <= 1'b0;
    end else begin
      rxDataValid <= 1'b0;
      if (rxLineValid) begin
        if (rxOnes_reg == rxThr) begin
          // Forced ZERO position, dropped
          rxOnes_reg <= 5'h00;
          rxLow_reg  <= 1'b1;
        end else begin
          rxDataValid <= 1'b1;
          rxData      <= rxLineBit ^ rxHist_reg[`AMF_TAP_A-1] ^ rxHist_reg[`AMF_TAP_B-1];
          rxHist_reg  <= {rxHist_reg[9:0], rxLineBit};
          if (rxLineBit) begin
            rxOnes_reg <= rxOnes_reg + 5'h01;
          end else begin
            rxOnes_reg <= 5'h00;
            rxLow_reg  <= 1'b0;
          end
        end
      end
    end
  end

endmodule

// ---- verification/amf_line_framer_checker.sv ----
// Port assertions for the customer-end line framer
`timescale 1ns/1ps
`include "amf_consts.vh"
module amf_line_framer_checker #(
  parameter TX_OFFSET = `AMF_TX_OFFSET
) (
  input wire       clk,
  input wire       sys_rst,
  input wire       bitTick,
  input wire       rxFrameStart,
  input wire       txMsgLoad,
  input wire       txNeedAck,
  input wire       linkActive,
  input wire       exchangeGo,
  input wire       powerDown,
  input wire       wholeActivate,
  input wire       txFrameStart,
  input wire       rxMsgValid,
  input wire [1:0] mfState,
  input wire       mfLoss,
  input wire       txBusy,
  input wire       txDrive,
  input wire       custIfEnable
);
  reg [9:0] tickCnt_reg; // Line bits since the last received frame start
  // Count line bits from each received frame start
  always @(posedge clk) begin
    if (sys_rst || rxFrameStart) begin
      tickCnt_reg <= 10'h000;
    end else if (bitTick) begin
      tickCnt_reg <= tickCnt_reg + 10'h001;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  property p_offs; txFrameStart |-> tickCnt_reg == TX_OFFSET; endproperty
  a_offs: assert property (p_offs) else $error("early tx frame");
  property p_hit; bitTick && !rxFrameStart && tickCnt_reg == TX_OFFSET - 1 |=> txFrameStart; endproperty
  a_hit: assert property (p_hit) else $error("missed tx frame");
  property p_drv; txDrive == (linkActive && exchangeGo && !powerDown); endproperty
  a_drv: assert property (p_drv) else $error("line drive wrong");
  property p_cust; custIfEnable == (linkActive && wholeActivate); endproperty
  a_cust: assert property (p_cust) else $error("interface enable wrong");
  property p_loss; mfLoss |-> mfState == `AMF_ST_OUT && $past(mfState) == `AMF_ST_PREALARM; endproperty
  a_loss: assert property (p_loss) else $error("loss without prealarm");
  property p_msg; rxMsgValid |-> mfState == `AMF_ST_ALIGNED; endproperty
  a_msg: assert property (p_msg) else $error("message while unaligned");
  property p_step; mfState == `AMF_ST_ALIGNED |=> mfState != `AMF_ST_OUT; endproperty
  a_step: assert property (p_step) else $error("prealarm skipped");
  property p_busy; txMsgLoad && !txBusy && txNeedAck && linkActive |=> txBusy; endproperty
  a_busy: assert property (p_busy) else $error("busy not raised");
  c_align: cover property (rxMsgValid);
  c_loss: cover property (mfLoss);
  c_frame: cover property (txFrameStart);
endmodule

// ---- verification/amf_exch_model.sv ----
// Exchange-end model: bit ticks, frame starts, service bits
`timescale 1ns/1ps
module amf_exch_model #(
  parameter FRAME_TICKS = 16 // Bits per frame, shortened
) (
  input  wire       clk,
  input  wire       sys_rst,
  input  wire       go,
  input  wire       corrupt,
  input  wire [8:0] msg,
  output wire       bitTick,
  output wire       rxFrameStart,
  output wire       rxSvcBit,
  output wire       rxSvcValid
);
  localparam [5:0] LAST = 2 * FRAME_TICKS - 1; // Two clocks per bit
  reg  [5:0]  phase_reg = 6'h00;
  reg  [1:0]  frame_reg = 2'h0;
  reg         lastBit_reg = 1'b0;
  wire [15:0] word; // Service word, first frame on top
  wire [1:0]  slot = phase_reg[2:1] - 2'h1;
  assign word[15:12] = {msg[8:6], ~^msg[8:6] ^ corrupt};
  assign word[11:4] = {msg[5:3], ^msg[5:3], msg[2:0], ^msg[2:0]};
  assign word[3:0] = word[15:12] ^ word[11:8] ^ word[7:4];
  assign rxFrameStart = go && phase_reg == 6'h00;
  assign bitTick = go && phase_reg[0];
  assign rxSvcValid = bitTick && phase_reg >= 6'h03 && phase_reg <= 6'h09;
  // Idle line shows the inverse of the last bit
  assign rxSvcBit = rxSvcValid ? word[~{frame_reg, slot}] : ~lastBit_reg;
  // Bit phase and multiframe position
  always @(posedge clk) begin
    if (sys_rst || !go) begin
      phase_reg <= 6'h00;
      frame_reg <= 2'h0;
    end else begin
      phase_reg <= (phase_reg == LAST) ? 6'h00 : phase_reg + 6'h01;
      frame_reg <= frame_reg + {1'b0, phase_reg == LAST};
    end
    if (rxSvcValid) lastBit_reg <= rxSvcBit;
  end
endmodule

// ---- verification/tb_top.sv ----
// Self-checking bench for the customer-end line framer
`timescale 1ns/1ps
`include "amf_consts.vh"
module tb_top;
  localparam [15:0] OFFS = 16'h0008; // Shortened upstream offset
  reg clk = 1'b0, sys_rst = 1'b1, go = 1'b0, corrupt = 1'b0, sawPre = 1'b0;
  reg txData = 1'b0, txDataValid = 1'b0, txSvcReq = 1'b0, txMsgLoad = 1'b0, txNeedAck = 1'b0, rxAckSeen = 1'b0;
  reg linkActive = 1'b0, exchangeGo = 1'b0, powerDown = 1'b0, wholeActivate = 1'b0;
  reg [8:0] txMsg = 9'h000, rxMsgIn = 9'h000;
  integer n_fail = 0, n_compared = 0;
  wire bitTick, rxFrameStart, rxSvcBit, rxSvcValid, txFrameStart, txSvcBit, rxMsgValid, mfLoss, txBusy;
  wire txDataReady, txLineBit, txLineValid, txParityBit, rxData, rxDataValid, txDrive, custIfEnable;
  wire [8:0] rxMsg;
  wire [1:0] mfState;
  wire rxLineBit = txLineBit; // Line looped back
  wire rxLineValid = txLineValid;
  wire [3:0] ev = {mfLoss, rxMsgValid, txFrameStart, rxFrameStart}; // Awaitable events
  amf_exch_model part_u (.clk, .sys_rst, .go, .corrupt, .msg(rxMsgIn), .bitTick, .rxFrameStart, .rxSvcBit,
    .rxSvcValid);
  amf_line_framer #(.TX_OFFSET(OFFS)) dut_u (.clk, .sys_rst, .bitTick, .rxFrameStart, .rxSvcBit, .rxSvcValid,
    .rxLineBit, .rxLineValid, .txData, .txDataValid, .txSvcReq, .txMsg, .txMsgLoad, .txNeedAck, .rxAckSeen,
    .linkActive, .exchangeGo, .powerDown, .wholeActivate, .txFrameStart, .txSvcBit, .rxMsg, .rxMsgValid, .mfState,
    .mfLoss, .txBusy, .txDataReady, .txLineBit, .txLineValid, .txParityBit, .rxData, .rxDataValid, .txDrive,
    .custIfEnable);
  initial forever #2.5 clk = ~clk;
  always @(posedge clk) if (mfState === `AMF_ST_PREALARM) sawPre <= 1'b1;
  task chk(input [15:0] got, input [15:0] exp);
    begin
      n_compared = n_compared + 1;
      if (got !== exp) begin
        n_fail = n_fail + 1;
        $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask
  task tally_and_finish;
    begin
      $display("Compared %0d, mismatches %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
    end
  endtask
  // Bounded wait for one event
  task wait_ev(input integer s);
    integer i;
    begin
      for (i = 0; i < 3000 && ev[s] !== 1'b1; i = i + 1) begin
        @(posedge clk);
        #1;
      end
      if (i == 3000) n_fail = n_fail + 1;
      if (i == 3000) tally_and_finish;
    end
  endtask
  task t_drive;
    integer i;
    begin
      for (i = 0; i < 16; i = i + 1) begin
        @(posedge clk);
        #1;
        {linkActive, exchangeGo, powerDown, wholeActivate} = i[3:0];
        #1;
        chk({txDrive, custIfEnable}, {i[3] & i[2] & !i[1], i[3] & i[0]});
      end
      @(posedge clk);
      #1;
      {linkActive, exchangeGo, powerDown} = 3'h6;
    end
  endtask
  task t_align;
    begin
      rxMsgIn = 9'h0a5; // Message bits the exchange end sends
      go = 1'b1;
      wait_ev(2);
      chk({rxMsg, mfState}, {9'h0a5, `AMF_ST_ALIGNED});
    end
  endtask
  task t_offset;
    integer n, c;
    begin
      n = 0;
      c = 0;
      wait_ev(0);
      while (txFrameStart !== 1'b1 && c < 500) begin
        @(posedge clk);
        #1;
        c = c + 1;
        if (bitTick === 1'b1) n = n + 1;
      end
      chk({txFrameStart, n[14:0]}, {1'b1, OFFS[14:0]});
      if (c == 500) tally_and_finish;
    end
  endtask
  task t_loss;
    begin
      corrupt = 1'b1;
      wait_ev(3);
      chk({sawPre, mfState}, {1'b1, `AMF_ST_OUT});
      corrupt = 1'b0;
      wait_ev(2);
      chk(mfState, `AMF_ST_ALIGNED);
    end
  endtask
  task t_msg;
    reg [31:0] w;
    reg hit;
    integer k;
    begin
      go = 1'b0;
      {txNeedAck, linkActive, txMsgLoad, txMsg} = {3'h5, 9'h1a5};
      @(posedge clk);
      #1;
      chk(txBusy, 1'b0);
      linkActive = 1'b1;
      @(posedge clk);
      #1;
      txMsgLoad = 1'b0;
      chk(txBusy, 1'b1);
      for (k = 0; k < 32; k = k + 1) begin
        txSvcReq = 1'b1;
        @(posedge clk);
        #1;
        txSvcReq = 1'b0;
        w = {w[30:0], txSvcBit};
        @(posedge clk);
        #1;
      end
      hit = 1'b0;
      // Word of 1A5 with its parity bits is D9AE, position unknown
      for (k = 0; k < 16; k = k + 1) hit = hit | ((w[15:0] << k | w[15:0] >> (16 - k)) == 16'hd9ae);
      chk({hit, w[31:16]}, {1'b1, w[15:0]});
      rxAckSeen = 1'b1;
      @(posedge clk);
      #1;
      rxAckSeen = 1'b0;
      chk(txBusy, 1'b0);
    end
  endtask
  task t_guard;
    reg [10:0] h;
    reg rdy;
    integer i, k, thr, z;
    begin
      h = 11'h000;
      k = 0;
      z = 0;
      thr = 16;
      for (i = 0; i < 70; i = i + 1) begin
        txData = (i != 50) ^ h[8] ^ h[10];
        txDataValid = 1'b1;
        rdy = txDataReady;
        @(posedge clk);
        #1;
        txDataValid = 1'b0;
        chk({txLineValid, !rdy, txLineBit}, {1'b1, k == thr, rdy && i != 50});
        if (!rdy || i == 50) z = z + 1;
        if (rdy) h = {h[9:0], txLineBit};
        if (txLineBit) k = k + 1;
        else k = 0;
        if (!rdy) thr = 2;
        else if (!txLineBit) thr = 16;
        @(posedge clk);
        #1;
        chk({rxDataValid, rxData | !rdy | i < 13}, {rdy, txData | !rdy | i < 13});
      end
      chk(txParityBit, !z[0]);
    end
  endtask
  initial begin
    repeat (2) @(posedge clk);
    #1;
    sys_rst = 1'b0;
    chk({mfState, txBusy, txLineBit, rxData, txParityBit, txSvcBit}, 16'h004e);
    t_drive;
    t_align;
    t_offset;
    t_loss;
    t_msg;
    t_guard;
    tally_and_finish;
  end
endmodule
bind amf_line_framer amf_line_framer_checker #(.TX_OFFSET(TX_OFFSET)) chk_u (.clk, .sys_rst, .bitTick,
  .rxFrameStart, .txMsgLoad, .txNeedAck, .linkActive, .exchangeGo, .powerDown, .wholeActivate, .txFrameStart,
  .rxMsgValid, .mfState, .mfLoss, .txBusy, .txDrive, .custIfEnable);
